// file: amad_map.svh
// constants for the a24 module address decode block: offsets, limits, counts
// assumes a 24-bit backplane address space and byte-wide module registers
`ifndef AMAD_MAP_SVH
`define AMAD_MAP_SVH

// backplane address width and the fixed step from block base to module base
`define AMAD_ADDR_W       24
`define AMAD_BASE_ADJ     24'h000001
`define AMAD_BASE_RST     24'h000000

// module window size in bytes and the legal switch range
`define AMAD_WINDOW_BYTES 1024
`define AMAD_SW_W         4
`define AMAD_SW_MIN       4'h1
`define AMAD_SW_MAX       4'hC

// register index width: one index per even byte in the window
`define AMAD_IDX_W        9
`define AMAD_DATA_W       8

`endif

// file: amad_pkg.sv
// types shared by the a24 module address decode block
// assumes amad_map.svh is on the include path
`include "amad_map.svh"

package amad_pkg;

   // one backplane access as presented by the control card
   typedef struct packed {
      logic                       write;    // 1 write, 0 read
      logic                       space24;  // access is in the 24-bit space
      logic                       byteWide; // single byte transfer
      logic [`AMAD_ADDR_W-1:0]    addr;
      logic [`AMAD_DATA_W-1:0]    wrData;
   } amad_bus_cmd_t;

   // strobe group toward the module's own byte registers
   typedef struct packed {
      logic                       wrStb;
      logic                       rdStb;
      logic [`AMAD_IDX_W-1:0]     idx;
      logic [`AMAD_DATA_W-1:0]    wrData;
   } amad_loc_port_t;

   typedef enum logic [1:0] {
      AMAD_ST_IDLE = 2'b00,
      AMAD_ST_DEC  = 2'b01,
      AMAD_ST_STB  = 2'b10,
      AMAD_ST_ACK  = 2'b11
   } amad_state_t;

endpackage

// file: amad_decode.sv
// address decode and byte access path from the control card to one module
// assumes all inputs synchronous to core_clk; the module's own registers sit
// behind locPort and return read data on locRdData in the strobe cycle
// assumes the card issues one access at a time and waits for busReady
// assumes the switches are strapped before reset is released
`timescale 1ns/1ps
`include "amad_map.svh"

module amad_decode #(
   parameter int WINDOW_BYTES = `AMAD_WINDOW_BYTES,
   parameter int SW_W         = `AMAD_SW_W
) (
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   input  wire logic                    busReq,
   input  wire amad_pkg::amad_bus_cmd_t busCmd,
   input  wire logic                    baseWrStb,
   input  wire logic [`AMAD_ADDR_W-1:0] baseWrData,
   input  wire logic [SW_W-1:0]         modSwitch,
   input  wire logic [`AMAD_DATA_W-1:0] locRdData,
   output logic                         allocReq,
   output logic                         baseValid,
   output logic                         busReady,
   output logic                         busAck,
   output logic                         busIgnored,
   output logic [`AMAD_DATA_W-1:0]      busRdData,
   output logic                         addrFault,
   output amad_pkg::amad_loc_port_t     locPort
);

   // address bits spanned by one module window
   localparam int WIN_LOG = $clog2(WINDOW_BYTES);

   // the window must be a power of two, fit the address space and give
   // no more even offsets than the index field can carry
   // a bad setting stops elaboration instead of decoding a wrong window
   generate
      if ((1 << WIN_LOG) != WINDOW_BYTES ||
          WIN_LOG + SW_W > `AMAD_ADDR_W ||
          WIN_LOG - 1 > `AMAD_IDX_W ||
          SW_W != `AMAD_SW_W) begin : g_bad_param
         $error("amad_decode: unsupported window or switch width");
      end
   endgenerate

   // sequencer state, captured request and address bookkeeping
   amad_pkg::amad_state_t      stateReg;
   amad_pkg::amad_state_t      stateNext;
   amad_pkg::amad_bus_cmd_t    cmdReg;
   logic [`AMAD_ADDR_W-1:0]    blockBaseReg;
   logic [`AMAD_ADDR_W-1:0]    modBaseReg;
   logic [`AMAD_ADDR_W-1:0]    modOffset;
   logic [`AMAD_ADDR_W-1:0]    winOffset;
   logic [SW_W-1:0]            modAddrReg;
   logic                       swTakenReg;
   logic                       addrOkReg;
   logic                       winHit;
   logic                       swInRange;
   logic                       stbFire;
   logic                       takeReq;

   // start-up allocation request: held until the base arrives
   // drops on the base strobe edge so it never overlaps baseValid
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         allocReq  <= 1'b0;
      end else begin
         allocReq  <= !baseValid && !baseWrStb;
      end
   end

   // block base from the resource manager; accesses taken before it are refused as misses
   // a later rewrite moves the window; no access should be in flight then
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         blockBaseReg <= `AMAD_BASE_RST;
         baseValid    <= 1'b0;
      end else if (baseWrStb) begin
         blockBaseReg <= baseWrData;
         baseValid    <= 1'b1;
      end
   end

   // legal switch range, read only by the capture below
   assign swInRange = modSwitch >= `AMAD_SW_MIN &&
                      modSwitch <= `AMAD_SW_MAX;

   // switch setting caught once, on the first edge after reset release;
   // later changes to the switches need a reset, as on a real strap
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         modAddrReg <= '0;
         swTakenReg <= 1'b0;
         addrOkReg  <= 1'b0;
         addrFault  <= 1'b0;
      end else if (!swTakenReg) begin
         swTakenReg <= 1'b1;
         modAddrReg <= modSwitch;
         // out-of-range setting blocks every window hit; misses are still answered
         addrOkReg  <= swInRange;
         addrFault  <= !swInRange;
      end
   end

   // module base recomputed every cycle from registered inputs only
   // the extra register keeps the adder off the compare path; it costs one
   // cycle after a base write; baseValid does not wait for it, so a decode one cycle after the write still sees the old base
   assign modOffset = `AMAD_ADDR_W'(modAddrReg) << WIN_LOG;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         modBaseReg <= `AMAD_BASE_RST;
      end else begin
         // sum wraps modulo the 24-bit space
         modBaseReg <= blockBaseReg + modOffset + `AMAD_BASE_ADJ;
      end
   end

   // window hit: right space, byte wide, inside window, even offset
   // odd offsets fall between registers and are refused, not rounded
   assign winOffset = cmdReg.addr - modBaseReg;
   assign winHit    = cmdReg.space24 &&
                      cmdReg.byteWide &&
                      addrOkReg && baseValid &&
                      winOffset < `AMAD_ADDR_W'(WINDOW_BYTES) &&
                      !winOffset[0];

   // one decode slot per access: take in idle, fire strobes in decode
   assign takeReq = stateReg == amad_pkg::AMAD_ST_IDLE && busReq;
   assign stbFire = stateReg == amad_pkg::AMAD_ST_DEC && winHit;

   // access sequencer: take, decode, strobe, answer
   // a hit is back in idle three edges after its take, a miss one
   always_comb begin
      stateNext = stateReg;
      case (stateReg)
         amad_pkg::AMAD_ST_IDLE: begin
            if (busReq) begin
               stateNext = amad_pkg::AMAD_ST_DEC;
            end
         end
         amad_pkg::AMAD_ST_DEC: begin
            if (winHit) begin
               stateNext = amad_pkg::AMAD_ST_STB;
            end else begin
               stateNext = amad_pkg::AMAD_ST_IDLE;
            end
         end
         amad_pkg::AMAD_ST_STB: begin
            stateNext = amad_pkg::AMAD_ST_ACK;
         end
         amad_pkg::AMAD_ST_ACK: begin
            stateNext = amad_pkg::AMAD_ST_IDLE;
         end
         default: begin
            stateNext = amad_pkg::AMAD_ST_IDLE;
         end
      endcase
   end

   // busReady looks one state ahead so the card may launch a request
   // in the very cycle the sequencer sits idle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stateReg <= amad_pkg::AMAD_ST_IDLE;
         busReady <= 1'b0;
      end else begin
         stateReg <= stateNext;
         busReady <= stateNext == amad_pkg::AMAD_ST_IDLE;
      end
   end

   // request captured only when idle; requests while busy are dropped
   // nothing is queued: the card must watch busReady before asking
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cmdReg <= '0;
      end else if (takeReq) begin
         cmdReg <= busCmd;
      end
   end

   // one-cycle strobes toward the module registers, index is offset / 2
   // idx and wrData hold after the strobe for slow register logic
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         locPort <= '0;
      end else if (stbFire) begin
         locPort.wrStb  <= cmdReg.write;
         locPort.rdStb  <= !cmdReg.write;
         locPort.idx    <= `AMAD_IDX_W'(winOffset[WIN_LOG-1:1]);
         locPort.wrData <= cmdReg.wrData;
      end else begin
         locPort.wrStb  <= 1'b0;
         locPort.rdStb  <= 1'b0;
      end
   end

   // answer: one byte per read, zero on writes, one-cycle acknowledge
   // busRdData holds until the next hit answers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busAck    <= 1'b0;
         busRdData <= '0;
      end else if (stateReg == amad_pkg::AMAD_ST_STB) begin
         busAck    <= 1'b1;
         busRdData <= cmdReg.write ? '0 : locRdData;
      end else begin
         busAck    <= 1'b0;
      end
   end

   // pulse when a taken request falls outside this module
   // lets the card end a miss at once instead of waiting for a timeout
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busIgnored <= 1'b0;
      end else begin
         busIgnored <= stateReg == amad_pkg::AMAD_ST_DEC && !winHit;
      end
   end

endmodule // amad_decode

// file: amad_decode_assertions.sv
// checker for amad_decode: strobe, ack and refusal timing
// assumes modSwitch only changes while rst_n is low
`timescale 1ns/1ps
`include "amad_map.svh"

module amad_decode_assertions #(
   parameter int SW_W = `AMAD_SW_W
) (
   input wire logic                     core_clk,
   input wire logic                     rst_n,
   input wire logic                     busReq,
   input wire amad_pkg::amad_bus_cmd_t  busCmd,
   input wire logic                     baseWrStb,
   input wire logic [SW_W-1:0]          modSwitch,
   input wire logic                     allocReq,
   input wire logic                     baseValid,
   input wire logic                     busReady,
   input wire logic                     busAck,
   input wire logic                     busIgnored,
   input wire logic                     addrFault,
   input wire amad_pkg::amad_loc_port_t locPort
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_strobe_cause: assert property (
      (locPort.rdStb || locPort.wrStb)
      |-> $past(busReq, 2) && $past(busReady, 2))
      else $error("bad strobe");
   a_ack_follows: assert property (
      (locPort.rdStb || locPort.wrStb)
      |=> busAck ##1 (busReady && !busAck))
      else $error("ack late");
   a_space_miss: assert property (
      busReady && busReq && !busCmd.space24
      |-> ##2 busIgnored ##1 !busAck)
      else $error("short space taken");
   a_width_miss: assert property (
      busReady && busReq && !busCmd.byteWide
      |-> ##2 busIgnored ##1 !busAck)
      else $error("wide access taken");
   a_fault_range: assert property (
      $past(rst_n, 2) && $past(rst_n)
      |-> addrFault == (modSwitch < 4'h1 || modSwitch > 4'hC))
      else $error("fault flag wrong");
   a_fault_block: assert property (
      addrFault |-> !locPort.rdStb && !locPort.wrStb)
      else $error("fault yet strobe");
   a_alloc_done: assert property (
      baseWrStb |=> baseValid && !allocReq)
      else $error("base not taken");
   a_miss_quiet: assert property (
      busIgnored |=> !busAck [*2])
      else $error("ack after miss");
endmodule // amad_decode_assertions

bind amad_decode amad_decode_assertions #(.SW_W(SW_W)) chk (.core_clk,
   .rst_n, .busReq, .busCmd, .baseWrStb, .modSwitch, .allocReq, .baseValid,
   .busReady, .busAck, .busIgnored, .addrFault, .locPort);

// file: amad_rm_model.sv
// resource manager stand-in: answers the block request with a base
// assumes allocReq stays high until the base write lands
`timescale 1ns/1ps

module amad_rm_model #(
   parameter logic [23:0] BLOCK_BASE = 24'h204000,
   parameter int          DLY        = 3
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        allocReq,
   output logic             baseWrStb,
   output logic [23:0]      baseWrData
);
   int waitCnt;

   // one base write, a few cycles late; data line shows junk otherwise
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         waitCnt    <= 0;
         baseWrStb  <= 1'b0;
         baseWrData <= ~BLOCK_BASE;
      end else begin
         waitCnt    <= allocReq ? waitCnt + 1 : 0;
         baseWrStb  <= allocReq && waitCnt == DLY;
         baseWrData <= (allocReq && waitCnt == DLY) ? BLOCK_BASE : ~BLOCK_BASE;
      end
   end
endmodule // amad_rm_model

// file: a24_module_address_decode_bench.sv
// bench for amad_decode: window hits, misses, switch range
// assumes amad_rm_model and the checker are compiled alongside
`timescale 1ns/1ps

module a24_module_address_decode_bench;
   logic core_clk = 1'b0, rst_n = 1'b0, busReq = 1'b0;
   logic [3:0] modSwitch = 4'h1;
   amad_pkg::amad_bus_cmd_t  busCmd = '0;
   amad_pkg::amad_loc_port_t locPort;
   logic baseWrStb, allocReq, baseValid, busReady, busAck, busIgnored;
   logic addrFault;
   logic [23:0] baseWrData, mb;
   logic [7:0]  busRdData, locRdData;
   int fail_count = 0, check_count = 0, cyc = 0;

   always #5 core_clk = ~core_clk;
   // register side answers with a pattern made from the index
   assign locRdData = locPort.idx[7:0] ^ 8'h5A;

   amad_decode uut (.core_clk, .rst_n, .busReq, .busCmd, .baseWrStb,
      .baseWrData, .modSwitch, .locRdData, .allocReq, .baseValid, .busReady,
      .busAck, .busIgnored, .busRdData, .addrFault, .locPort);
   amad_rm_model rm (.core_clk, .rst_n, .allocReq, .baseWrStb, .baseWrData);

   task automatic chk(input string nm, input logic [23:0] e, g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic results;
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles needed
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         results();
      end
   end

   // one access: wait idle, request one cycle, judge c2 and c3
   task automatic acc(input logic wr, sp, bw, input logic [23:0] a,
                      input logic [7:0] d, input logic hit);
      logic [23:0] off;
      int n;
      off = a - mb;
      n = 0;
      while (busReady !== 1'b1 && n < 10) begin
         @(negedge core_clk);
         n++;
      end
      chk("busReady", 1'b1, busReady);
      busReq = 1'b1;
      busCmd = '{wr, sp, bw, a, d};
      @(negedge core_clk);
      busReq = 1'b0;
      @(negedge core_clk);
      chk("rdStb", hit & ~wr, locPort.rdStb);
      chk("wrStb", hit & wr, locPort.wrStb);
      chk("ignored", !hit, busIgnored);
      chk("busReady", !hit, busReady);
      if (hit) chk("idx", off >> 1, locPort.idx);
      if (hit && wr) chk("wrData", d, locPort.wrData);
      @(negedge core_clk);
      chk("ack", hit, busAck);
      if (hit && !wr) chk("rdData", off[8:1] ^ 8'h5A, busRdData);
      if (hit && wr) chk("rdData", 24'h000000, busRdData);
   endtask

   // reset with a switch value, then walk the window edges
   task automatic window(input logic [3:0] sw, input logic ok);
      @(negedge core_clk);
      rst_n = 1'b0;
      modSwitch = sw;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge core_clk);
      chk("baseValid", 1'b1, baseValid);
      chk("allocReq", 1'b0, allocReq);
      chk("addrFault", !ok, addrFault);
      mb = 24'h204000 + {sw, 10'h000} + 24'h000001;
      acc(0, 1, 1, mb + 24'h000016, 8'h00, ok);
      acc(1, 1, 1, mb + 24'h000018, 8'h50, ok);
      acc(1, 1, 1, mb + 24'h0003FE, 8'hC3, ok); // last even byte
      acc(0, 1, 1, mb + 24'h000003, 8'h00, 0); // odd offset
      acc(0, 1, 1, mb + 24'h000400, 8'h00, 0); // next window
      acc(0, 1, 1, mb - 24'h000001, 8'h00, 0); // below window
      acc(0, 0, 1, mb, 8'h00, 0); // short space
      acc(1, 1, 0, mb, 8'h00, 0); // not byte wide
   endtask

   initial begin
      window(4'h1, 1'b1);
      window(4'h2, 1'b1);
      window(4'hC, 1'b1);
      window(4'h0, 1'b0);
      window(4'hD, 1'b0);
      results();
   end
endmodule // a24_module_address_decode_bench
